// [ddrs_pkg.sv]
package ddrs_pkg;

  // organisations: total address bits, including the burst start bit
  localparam int X18_ADDR_W = 21;
  localparam int X18_DATA_W = 18;
  localparam int X36_ADDR_W = 20;
  localparam int X36_DATA_W = 36;

  // byte lane width and burst shape
  localparam int LANE_W      = 9;
  localparam int BURST_WORDS = 2;
  localparam int NUM_BANKS   = 2;

  // pin encodings
  localparam logic DIR_READ    = 1'b1;
  localparam logic LANE_WRITE  = 1'b0;
  localparam logic OE_DRIVE    = 1'b0;
  localparam logic OE_RELEASE  = 1'b1;
  localparam logic DLL_ON      = 1'b1;

  // reset values
  localparam logic SYNC_RST_VAL = 1'b0;
  localparam logic VLD_RST_VAL  = 1'b0;

endpackage

// [ddrs_bank_if.sv]
`timescale 1ns/100ps
interface ddrs_bank_if #(
  parameter int ROW_W = 20,
  parameter int DW    = 18,
  parameter int LN    = 2
);
  logic             we;
  logic [ROW_W-1:0] waddr;
  logic [ROW_W-1:0] raddr;
  logic [DW-1:0]    wdata;
  logic [LN-1:0]    lane_n;
  logic [DW-1:0]    rdata;

  modport ctrl (output we, output waddr, output raddr, output wdata, output lane_n, input rdata);
  modport mem  (input we, input waddr, input raddr, input wdata, input lane_n, output rdata);
endinterface

// [ddrs_sync.sv]
`timescale 1ns/100ps
module ddrs_sync
  import ddrs_pkg::*;
#(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  // asynchronous levels in, synchronised levels out
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] meta_r;
  logic [W-1:0] stab_r;

  // first stage feeds only the second
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_r <= {W{SYNC_RST_VAL}};
      stab_r <= {W{SYNC_RST_VAL}};
    end else begin
      meta_r <= d_in;
      stab_r <= meta_r;
    end
  end

  assign q_out = stab_r;

endmodule

// [ddrs_bank.sv]
`timescale 1ns/100ps
module ddrs_bank
  import ddrs_pkg::*;
#(
  parameter int ROW_W = 20,
  parameter int DW    = 18,
  parameter int LN    = 2
) (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // port to the controller logic
  ddrs_bank_if.mem  bus
);

  localparam int DEPTH = 1 << ROW_W;

  logic [DW-1:0] mem_r [DEPTH];
  logic [DW-1:0] old_word;
  logic [DW-1:0] merged_word;

  assign old_word = mem_r[bus.waddr];

  // per-lane merge of new data over the stored word
  always_comb begin
    merged_word = old_word;
    for (int i = 0; i < LN; i++) begin
      if (bus.lane_n[i] == LANE_WRITE) begin
        merged_word[i*LANE_W +: LANE_W] = bus.wdata[i*LANE_W +: LANE_W];
      end
    end
  end

  // array has no reset; contents are undefined until written
  always_ff @(posedge clk_in) begin
    if (bus.we) begin
      mem_r[bus.waddr] <= merged_word;
    end
  end

  assign bus.rdata = mem_r[bus.raddr];

  a_lane_merge: assert property (@(posedge clk_in) disable iff (rst_in)
    bus.we |=> mem_r[$past(bus.waddr)] == $past(merged_word))
    else $error("written word does not match lane merge");

endmodule

// [ddrs_port.sv]
`timescale 1ns/100ps
module ddrs_port
  import ddrs_pkg::*;
#(
  parameter int ADDR_W = X18_ADDR_W,
  parameter int DATA_W = X18_DATA_W
) (
  // system clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  // input clock pair and output clock pair
  input  wire logic              in_clk_p_in,
  input  wire logic              in_clk_n_in,
  input  wire logic              out_clk_p_in,
  input  wire logic              out_clk_n_in,
  // static mode pins
  input  wire logic              single_clock_mode_in,
  input  wire logic              delay_loop_disable_n_in,
  // command and address
  input  wire logic              load_strobe_n_in,
  input  wire logic              read_not_write_in,
  input  wire logic [ADDR_W-2:0] addr_in,
  input  wire logic              burst_start_bit_in,
  input  wire logic [DATA_W/LANE_W-1:0] byte_lane_write_n_in,
  // shared data pins
  input  wire logic [DATA_W-1:0] dq_in,
  output logic      [DATA_W-1:0] dq_out,
  output logic                   dq_oe_n_out,
  // echo clocks
  output logic                   returned_strobe_out,
  output logic                   returned_strobe_n_out
);

  localparam int ROW_W = ADDR_W - 1;
  localparam int LN    = DATA_W / LANE_W;
  localparam int SW    = 8 + ADDR_W + LN + DATA_W;

  if (DATA_W % LANE_W != 0 || DATA_W < LANE_W || ADDR_W < 2 || ADDR_W > X18_ADDR_W) begin : g_bad_cfg
    $error("ddrs_port: unsupported width configuration");
  end

  // synchronised pins
  logic [SW-1:0]     sync_d;
  logic [SW-1:0]     sync_q;
  logic              k_s;
  logic              kb_s;
  logic              c_s;
  logic              cb_s;
  logic              single_s;
  logic              dll_n_s;
  logic              ld_n_s;
  logic              rw_s;
  logic [ROW_W-1:0]  row_s;
  logic              start_s;
  logic [LN-1:0]     lane_s;
  logic [DATA_W-1:0] dq_s;

  assign sync_d = {in_clk_p_in, in_clk_n_in, out_clk_p_in, out_clk_n_in,
                   single_clock_mode_in, delay_loop_disable_n_in, load_strobe_n_in,
                   read_not_write_in, addr_in, burst_start_bit_in, byte_lane_write_n_in, dq_in};
  // clocks, strobes and data share one delay so their sample alignment holds
  assign {k_s, kb_s, c_s, cb_s, single_s, dll_n_s, ld_n_s, rw_s, row_s, start_s, lane_s, dq_s} = sync_q;

  ddrs_sync #(.W(SW)) u_sync (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .d_in   (sync_d),
    .q_out  (sync_q)
  );

  // edge detection on the sampled link clocks
  logic k_d_r;
  logic kb_d_r;
  logic c_d_r;
  logic cb_d_r;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      k_d_r  <= SYNC_RST_VAL;
      kb_d_r <= SYNC_RST_VAL;
      c_d_r  <= SYNC_RST_VAL;
      cb_d_r <= SYNC_RST_VAL;
    end else begin
      k_d_r  <= k_s;
      kb_d_r <= kb_s;
      c_d_r  <= c_s;
      cb_d_r <= cb_s;
    end
  end

  wire k_rise  = k_s & ~k_d_r;
  wire kb_rise = kb_s & ~kb_d_r;
  wire c_rise  = c_s & ~c_d_r;
  wire cb_rise = cb_s & ~cb_d_r;

  // output timing source
  wire opos_rise = single_s ? k_rise : c_rise;
  wire oneg_rise = single_s ? kb_rise : cb_rise;
  wire echo_lvl  = single_s ? k_s : c_s;
  wire dll_on    = (dll_n_s == DLL_ON);

  // command decode
  wire cmd_take = k_rise & ~ld_n_s;
  wire rd_take  = cmd_take & (rw_s == DIR_READ);
  wire wr_take  = cmd_take & (rw_s != DIR_READ);

  // banks
  logic [DATA_W-1:0] rd_word [NUM_BANKS];
  logic [NUM_BANKS-1:0] bank_we;
  logic [ROW_W-1:0]  wr_row_r;
  logic              wr_start_r;
  logic              wr_pend_r;
  logic              wr_second_r;

  wire beat0_fire = kb_rise & wr_pend_r;
  wire beat1_fire = k_rise & wr_second_r;
  wire wr_bank    = beat0_fire ? wr_start_r : ~wr_start_r;

  ddrs_bank_if #(.ROW_W(ROW_W), .DW(DATA_W), .LN(LN)) bif [NUM_BANKS] ();

  for (genvar g = 0; g < NUM_BANKS; g++) begin : g_bank
    assign bank_we[g]      = (beat0_fire | beat1_fire) & (wr_bank == 1'(g));
    assign bif[g].we       = bank_we[g];
    assign bif[g].waddr    = wr_row_r;
    assign bif[g].raddr    = row_s;
    assign bif[g].wdata    = dq_s;
    assign bif[g].lane_n   = lane_s;
    assign rd_word[g]      = bif[g].rdata;

    ddrs_bank #(.ROW_W(ROW_W), .DW(DATA_W), .LN(LN)) u_bank (
      .clk_in (clk_in),
      .rst_in (rst_in),
      .bus    (bif[g])
    );
  end

  // start bit picks the first bank, the wrapped bit the second
  wire [DATA_W-1:0] fetch_w0 = rd_word[start_s];
  wire [DATA_W-1:0] fetch_w1 = rd_word[~start_s];

  // write sequencing: beat 0 on the next negative rise, beat 1 on the next positive rise
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_pend_r   <= VLD_RST_VAL;
      wr_second_r <= VLD_RST_VAL;
      wr_row_r    <= '0;
      wr_start_r  <= 1'b0;
    end else begin
      if (wr_take) begin
        wr_pend_r  <= 1'b1;
        wr_row_r   <= row_s;
        wr_start_r <= start_s;
      end else if (beat0_fire) begin
        wr_pend_r  <= 1'b0;
      end
      if (beat0_fire) begin
        wr_second_r <= 1'b1;
      end else if (beat1_fire) begin
        wr_second_r <= 1'b0;
      end
    end
  end

  // read pipeline: pending burst, then current burst on the output clock
  logic              rp_vld_r;
  logic [DATA_W-1:0] rp_w0_r;
  logic [DATA_W-1:0] rp_w1_r;
  logic              rc_vld_r;
  logic [DATA_W-1:0] rc_w0_r;
  logic [DATA_W-1:0] rc_w1_r;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rp_vld_r <= VLD_RST_VAL;
      rc_vld_r <= VLD_RST_VAL;
      rp_w0_r  <= '0;
      rp_w1_r  <= '0;
      rc_w0_r  <= '0;
      rc_w1_r  <= '0;
    end else begin
      if (opos_rise) begin
        rc_vld_r <= rp_vld_r;
        rc_w0_r  <= rp_w0_r;
        rc_w1_r  <= rp_w1_r;
      end
      if (rd_take) begin
        rp_vld_r <= 1'b1;
        rp_w0_r  <= fetch_w0;
        rp_w1_r  <= fetch_w1;
      end else if (opos_rise) begin
        rp_vld_r <= 1'b0;
      end
    end
  end

  // launch choice per output edge
  wire              pos_drv  = dll_on ? rc_vld_r : rp_vld_r;
  wire [DATA_W-1:0] pos_word = dll_on ? rc_w1_r : rp_w0_r;
  wire [DATA_W-1:0] neg_word = dll_on ? rc_w0_r : rc_w1_r;

  logic [DATA_W-1:0] dq_r;
  logic              dq_oe_n_r;
  logic              echo_r;
  logic              echo_n_r;

  // positive edge wins if both are seen in one sample; clocks that close are out of range
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      dq_r      <= '0;
      dq_oe_n_r <= OE_RELEASE;
    end else if (opos_rise) begin
      dq_oe_n_r <= pos_drv ? OE_DRIVE : OE_RELEASE;
      if (pos_drv) begin
        dq_r <= pos_word;
      end
    end else if (oneg_rise) begin
      dq_oe_n_r <= rc_vld_r ? OE_DRIVE : OE_RELEASE;
      if (rc_vld_r) begin
        dq_r <= neg_word;
      end
    end
  end

  // echo pair runs whenever its source clock runs, reads or not
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      echo_r   <= 1'b0;
      echo_n_r <= 1'b1;
    end else begin
      echo_r   <= echo_lvl;
      echo_n_r <= ~echo_lvl;
    end
  end

  assign dq_out                = dq_r;
  assign dq_oe_n_out           = dq_oe_n_r;
  assign returned_strobe_out   = echo_r;
  assign returned_strobe_n_out = echo_n_r;

  // checks
  // k and c rise together in most systems, so the check must not exclude output edges
  a_deselect_ignored: assert property (@(posedge clk_in) disable iff (rst_in)
    (k_rise && ld_n_s) |=> (rp_vld_r == ($past(rp_vld_r) && !$past(opos_rise)))
      && (wr_pend_r == ($past(wr_pend_r) && !$past(beat0_fire))))
    else $error("deselected cycle started an access");

  a_write_capture: assert property (@(posedge clk_in) disable iff (rst_in)
    wr_take |=> wr_pend_r && (wr_row_r == $past(row_s)) && (wr_start_r == $past(start_s)))
    else $error("write command not captured");

  a_read_capture: assert property (@(posedge clk_in) disable iff (rst_in)
    rd_take |=> rp_vld_r && (rp_w0_r == $past(fetch_w0)) && !wr_pend_r == !$past(wr_pend_r && !beat0_fire))
    else $error("read command not captured");

  a_beat0_bank: assert property (@(posedge clk_in) disable iff (rst_in)
    beat0_fire |-> bank_we[wr_start_r] && !bank_we[~wr_start_r])
    else $error("first write beat in wrong bank");

  a_beat1_wrap: assert property (@(posedge clk_in) disable iff (rst_in)
    beat1_fire |-> bank_we[~wr_start_r] && !bank_we[wr_start_r] && !wr_pend_r)
    else $error("second write beat not in wrapped bank");

  a_write_order: assert property (@(posedge clk_in) disable iff (rst_in)
    beat0_fire |=> wr_second_r && !bank_we[0] && !bank_we[1])
    else $error("second beat not armed after first");

  a_pos_launch: assert property (@(posedge clk_in) disable iff (rst_in)
    (opos_rise && pos_drv) |=> !dq_oe_n_r && (dq_r == ($past(dll_on) ? $past(rc_w1_r) : $past(rp_w0_r))))
    else $error("wrong word on positive output edge");

  a_neg_launch: assert property (@(posedge clk_in) disable iff (rst_in)
    (oneg_rise && !opos_rise && rc_vld_r) |=> !dq_oe_n_r && (dq_r == ($past(dll_on) ? $past(rc_w0_r) : $past(rc_w1_r))))
    else $error("wrong word on negative output edge");

  a_idle_release: assert property (@(posedge clk_in) disable iff (rst_in)
    ((opos_rise || oneg_rise) && !rc_vld_r && !rp_vld_r) |=> dq_oe_n_r)
    else $error("data pins driven with no read");

  a_echo_follow: assert property (@(posedge clk_in) disable iff (rst_in)
    opos_rise |=> echo_r && !echo_n_r)
    else $error("echo pair not following output clock");

endmodule

// [ddrs_ctrl_model.sv]
`timescale 1ns/100ps
module ddrs_ctrl_model
  import ddrs_pkg::*;
#(
  parameter int AW = 6
) (
  // clock and mode
  input  wire logic        clk_in,
  input  wire logic        single_in,
  // link clocks
  output logic             k_out,
  output logic             kb_out,
  output logic             c_out,
  output logic             cb_out,
  // command, address, write data
  output logic             ld_n_out,
  output logic             rnw_out,
  output logic [AW-2:0]    addr_out,
  output logic             start_out,
  output logic [1:0]       lane_n_out,
  output logic [17:0]      dq_out,
  // memory answers
  input  wire logic [17:0] dq_in,
  input  wire logic        oe_n_in,
  input  wire logic        echo_in
);
  logic [AW+41:0] cmd_q[$];
  logic [18:0]    rd_q[$];
  // declared values, so a clock edge at time zero cannot race them
  logic [AW+41:0] cur_r = '0;
  logic [AW+41:0] nx;
  logic [2:0]     ph_r  = 3'h0;
  logic           w0_r  = 1'b0;
  logic           w1_r  = 1'b0;
  logic           e_r;
  logic           lvl_r;
  logic [1:0]     cnt_r;
  logic           c_sel;
  logic           c_rnw;
  logic [AW-1:0]  c_addr;
  logic [17:0]    c_d0;
  logic [17:0]    c_d1;
  logic [1:0]     c_l0;
  logic [1:0]     c_l1;
  assign {c_sel, c_rnw, c_addr, c_d0, c_d1, c_l0, c_l1} = cur_r;
  // output pair stands still in single-clock mode
  assign k_out = ~ph_r[2];
  assign kb_out = ph_r[2];
  assign c_out = ~single_in & ~ph_r[2];
  assign cb_out = single_in | ph_r[2];
  assign ld_n_out = ~c_sel;
  assign rnw_out = c_rnw;
  assign addr_out = c_addr[AW-1:1];
  assign start_out = c_addr[0];
  initial begin
    e_r = 1'b0;
    lvl_r = 1'b0;
    cnt_r = 2'h0;
    lane_n_out = 2'h3;
    dq_out = 18'h0;
  end
  task automatic push(input logic [AW+41:0] c);
    cmd_q.push_back(c);
  endtask
  // two clk of setup and hold around each link edge; idle lines flip
  always @(negedge clk_in) begin
    ph_r <= ph_r + 3'h1;
    if (ph_r == 3'h1) begin
      dq_out <= w0_r ? c_d0 : ~dq_out;
      lane_n_out <= w0_r ? c_l0 : ~lane_n_out;
      w1_r <= w0_r;
      w0_r <= 1'b0;
    end
    if (ph_r == 3'h5) begin
      dq_out <= w1_r ? c_d1 : ~dq_out;
      lane_n_out <= w1_r ? c_l1 : ~lane_n_out;
      w1_r <= 1'b0;
      nx = (cmd_q.size() > 0) ? cmd_q.pop_front() : {1'b0, ~cur_r[AW+40:0]};
      cur_r <= nx;
      w0_r <= nx[AW+41] & ~nx[AW+40];
    end
  end
  // sample late in the beat, three clk after each echo edge
  always @(posedge clk_in) begin
    e_r <= echo_in;
    cnt_r <= (echo_in != e_r) ? 2'h2 : ((cnt_r != 2'h0) ? cnt_r - 2'h1 : 2'h0);
    if (echo_in != e_r) lvl_r <= echo_in;
    if (cnt_r == 2'h1 && oe_n_in == OE_DRIVE) rd_q.push_back({lvl_r, dq_in});
  end
endmodule

// [test_ddr2_sram_two_word_burst_port.sv]
`timescale 1ns/100ps
module test_ddr2_sram_two_word_burst_port
  import ddrs_pkg::*;
;
  localparam int AW = 6;
  logic          clk;
  logic          rst;
  logic          sgl;
  logic          dll;
  logic          k;
  logic          kb;
  logic          c;
  logic          cb;
  logic          ld_n;
  logic          rnw;
  logic          start;
  logic [AW-2:0] addr;
  logic [1:0]    lane_n;
  logic [17:0]   m_dq;
  logic [17:0]   d_dq;
  logic [17:0]   dq;
  logic          oe_n;
  logic          echo;
  logic          echo_n;
  integer        fail_count;
  integer        tests_run;
  logic [17:0]   mem[64];
  logic [18:0]   exp_q[$];
  assign dq = (oe_n == OE_DRIVE) ? d_dq : m_dq;
  ddrs_port #(.ADDR_W(AW), .DATA_W(18)) u_dut (
    .clk_in(clk), .rst_in(rst), .in_clk_p_in(k), .in_clk_n_in(kb),
    .out_clk_p_in(c), .out_clk_n_in(cb), .single_clock_mode_in(sgl),
    .delay_loop_disable_n_in(dll), .load_strobe_n_in(ld_n), .read_not_write_in(rnw),
    .addr_in(addr), .burst_start_bit_in(start), .byte_lane_write_n_in(lane_n),
    .dq_in(dq), .dq_out(d_dq), .dq_oe_n_out(oe_n),
    .returned_strobe_out(echo), .returned_strobe_n_out(echo_n));
  ddrs_ctrl_model #(.AW(AW)) u_ctrl (
    .clk_in(clk), .single_in(sgl), .k_out(k), .kb_out(kb), .c_out(c), .cb_out(cb),
    .ld_n_out(ld_n), .rnw_out(rnw), .addr_out(addr), .start_out(start),
    .lane_n_out(lane_n), .dq_out(m_dq), .dq_in(dq), .oe_n_in(oe_n), .echo_in(echo));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wlane(input logic [5:0] a, input logic [17:0] d, input logic [1:0] l);
    for (int i = 0; i < 2; i++) if (l[i] == LANE_WRITE) mem[a][i*9+:9] = d[i*9+:9];
  endtask
  task automatic wr(input logic [5:0] a, input logic [17:0] d0, input logic [17:0] d1,
                    input logic [1:0] l0, input logic [1:0] l1);
    u_ctrl.push({1'b1, 1'b0, a, d0, d1, l0, l1});
    wlane(a, d0, l0);
    wlane(a ^ 6'h01, d1, l1);
  endtask
  // legacy puts word0 on the output positive edge, dll mode on the negative
  task automatic rd(input logic [5:0] a);
    u_ctrl.push({1'b1, 1'b1, a, 40'h0});
    exp_q.push_back({~dll, mem[a]});
    exp_q.push_back({dll, mem[a ^ 6'h01]});
  endtask
  // reads fetch at command time, so writes must land before reading back
  task automatic drain();
    int n;
    n = 0;
    while (u_ctrl.cmd_q.size() > 0 && n < 500) begin
      @(negedge clk);
      n++;
    end
    repeat (48) @(negedge clk);
  endtask
  task automatic chk_reads();
    logic [18:0] g;
    chk("read count", exp_q.size(), u_ctrl.rd_q.size());
    while (exp_q.size() > 0) begin
      g = (u_ctrl.rd_q.size() > 0) ? u_ctrl.rd_q.pop_front() : 'x;
      chk("read word", exp_q.pop_front(), g);
    end
    u_ctrl.rd_q.delete();
    chk("released", OE_RELEASE, oe_n);
  endtask
  task automatic mode(input logic s, input logic d);
    sgl = s;
    dll = d;
    repeat (16) @(negedge clk);
  endtask
  task automatic t_echo();
    int n;
    int bad;
    logic p;
    n = 0;
    bad = 0;
    // synchronisers hold zero for a few clk after reset
    repeat (4) @(negedge clk);
    @(negedge clk) p = echo;
    repeat (32) begin
      @(negedge clk);
      if (echo !== p) n++;
      if (echo_n !== ~echo) bad++;
      p = echo;
    end
    chk("echo toggles", 8, n);
    chk("echo pair", 0, bad);
  endtask
  task automatic t_legacy();
    mode(1'b0, 1'b0);
    wr(6'h06, 18'h12345, 18'h0ABCD, 2'h0, 2'h0);
    wr(6'h0B, 18'h3C3C3, 18'h21212, 2'h0, 2'h0);
    drain();
    rd(6'h07);
    rd(6'h0A);
    drain();
    chk_reads();
  endtask
  task automatic t_lanes();
    wr(6'h06, 18'h3FFFF, 18'h3FFFF, 2'h2, 2'h1);
    drain();
    rd(6'h06);
    drain();
    chk_reads();
  endtask
  task automatic t_desel();
    u_ctrl.push({1'b0, 1'b0, 6'h06, 18'h0, 18'h0, 2'h0, 2'h0});
    u_ctrl.push({1'b0, 1'b1, 6'h0A, 40'h0});
    rd(6'h06);
    drain();
    chk_reads();
  endtask
  task automatic t_dll();
    mode(1'b0, DLL_ON);
    rd(6'h07);
    rd(6'h0A);
    rd(6'h06);
    drain();
    chk_reads();
  endtask
  task automatic t_single();
    mode(1'b1, DLL_ON);
    t_echo();
    wr(6'h21, 18'h2468A, 18'h13579, 2'h0, 2'h0);
    drain();
    rd(6'h20);
    drain();
    chk_reads();
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    stop_test();
  end
  initial begin
    rst = 1'b1;
    sgl = 1'b0;
    dll = 1'b0;
    fail_count = 0;
    tests_run = 0;
    repeat (10) @(negedge clk);
    chk("reset oe", OE_RELEASE, oe_n);
    chk("reset echo", 2'h1, {echo, echo_n});
    rst = 1'b0;
    t_echo();
    t_legacy();
    t_lanes();
    t_desel();
    t_dll();
    t_single();
    stop_test();
  end
endmodule
